// ---- core/ssrp_pkg.sv ----
// Purpose: shared constants and types for the sensor serial register port
// Assumes: one core clock at 125 MHz, serial clock sampled as plain input
// Notes:   every width, count and timing figure of the port lives here
package ssrp_pkg;

	// access format
	localparam int ADDR_W    = 9;
	localparam int DATA_W    = 16;
	localparam int REG_DEPTH = 512;
	localparam int CNT_W     = 5;
	// count value at the type bit and at the last data bit
	localparam logic [CNT_W-1:0] TYPE_CNT = 5'h0_009;
	localparam logic [CNT_W-1:0] LAST_CNT = 5'h0_00F;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h0_000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h0_001;

	// access type carried by the tenth bit
	localparam logic TYPE_WRITE = 1'b1;

	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
	localparam logic              PIN_RST  = 1'b0;
	localparam logic              SEL_RST  = 1'b1;

	// link timing, in ns, and its worth in core cycles
	localparam int CORE_PERIOD_NS = 8;
	localparam int SCK_MIN_NS     = 100;
	localparam int SCK_MIN_CYC    = SCK_MIN_NS / CORE_PERIOD_NS;
	localparam int GAP_MIN_NS     = 2 * SCK_MIN_NS;
	localparam int GAP_MIN_CYC    = GAP_MIN_NS / CORE_PERIOD_NS;

	// port sequence; gray steps along idle, command, data, hold
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD  = 3'b001,
		ST_WR   = 3'b011,
		ST_RD   = 3'b101,
		ST_HOLD = 3'b111
	} ssrp_state_t;

	// completed write as seen by the sensor core
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ssrp_wr_t;

endpackage

// ---- core/ssrp_port.sv ----
// Purpose: four-wire serial slave reaching the 16-bit configuration registers
// Assumes: sck at most 10 MHz, so every level lasts several core cycles
// Notes:   serial pins are oversampled by core_clk_i through two flip-flops
`timescale 1ns/10ps

// Overview of operation
// (R01) An access is a 9-bit register address and a 16-bit data word.
// (R02) The master lowers select and a serial clock later sends the address msb first.
// (R03) Every master-out bit is captured at a rising serial clock edge.
// (R04) The master changes master-out on falling edges so it is steady at rises.
// (R05) The tenth bit picks the access: one writes and zero reads.
// (R06) A write continues with the 16-bit data word msb first.
// (R07) A read returns the addressed word on master-in msb first after the type bit.
// (R08) The master samples master-in on falling edges at no more than 10 MHz.
// (R09) The master waits one serial period after the last bit, then raises select.
// (R10) The serial clock stays at or below the fraction of the input clock allowed.
// (R11) At nominal input clocks the serial clock never passes 10 MHz.
// (R12) Between accesses the master keeps select high for two serial periods.
// (R13) The link runs on the master clock and crosses safely into the core domain.
// (R14) Master-in is released whenever no read data is being returned.
// (R15) Writes land after all 16 bits; reads return the current register word.
module ssrp_port (
	// clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      rst_i,
	// serial pins
	input  wire logic                      sck_i,
	input  wire logic                      sel_n_i,
	input  wire logic                      mosi_i,
	output logic                           miso_o,
	output logic                           miso_oe_o,
	// sensor core side
	input  wire logic [ssrp_pkg::ADDR_W-1:0] cfg_addr_i,
	output logic      [ssrp_pkg::DATA_W-1:0] cfg_data_o,
	output logic                           wr_valid_o,
	output ssrp_pkg::ssrp_wr_t             wr_o,
	output logic                           busy_o
);
	import ssrp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       sck_prev_reg;
	logic       sck_s;
	logic       sel_n_s;
	logic       mosi_s;
	logic       sck_rise;

	// first stage feeds only the second; pins are async to core_clk_i (R13)
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg    <= {SEL_RST, PIN_RST, PIN_RST};
			sync2_reg    <= {SEL_RST, PIN_RST, PIN_RST};
			sck_prev_reg <= PIN_RST;
		end else begin
			sync1_reg    <= {sel_n_i, mosi_i, sck_i};
			sync2_reg    <= sync1_reg;
			sck_prev_reg <= sync2_reg[0];
		end
	end

	// mosi shares the sck delay, so the rise sees the settled bit (R04)
	assign sck_s    = sync2_reg[0];
	assign mosi_s   = sync2_reg[1];
	assign sel_n_s  = sync2_reg[2];
	assign sck_rise = sck_s & ~sck_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// register array

	logic [DATA_W-1:0] regs_mem [REG_DEPTH];
	logic [DATA_W-1:0] rd_word;
	logic              mem_we;
	ssrp_wr_t          mem_wr;

	// no reset on the array; a register reads unknown until first written
	always_ff @(posedge core_clk_i) begin
		if (mem_we) begin
			regs_mem[mem_wr.addr] <= mem_wr.data; // (R15)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// access sequence

	ssrp_state_t       state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg, cnt_next;
	logic [DATA_W-1:0] sh_reg, sh_next;
	logic [DATA_W-1:0] rd_sh_reg, rd_sh_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic              miso_reg, miso_next;
	logic              oe_reg, oe_next;
	logic              wv_reg, wv_next;
	ssrp_wr_t          wr_reg, wr_next;
	logic [DATA_W-1:0] sh_in;

	// word lookup for a read uses the address bits just shifted in
	assign rd_word = regs_mem[sh_reg[ADDR_W-1:0]]; // (R15)
	assign sh_in   = {sh_reg[DATA_W-2:0], mosi_s}; // (R03)

	// all moves but the one out of idle happen on a detected rise; select high aborts anything
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		rd_sh_next = rd_sh_reg;
		addr_next  = addr_reg;
		miso_next  = miso_reg;
		oe_next    = oe_reg;
		wv_next    = 1'b0;
		wr_next    = wr_reg;
		mem_we     = 1'b0;
		mem_wr     = '{addr: addr_reg, data: sh_in};
		if (sel_n_s) begin
			state_next = ST_IDLE;
			oe_next    = 1'b0; // (R14)
			miso_next  = PIN_RST;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				// lead-in period after select carries no bit (R02)
				state_next = ST_CMD;
				cnt_next   = CNT_ZERO;
				sh_next    = DATA_RST;
			end
			ST_CMD: if (sck_rise) begin
				sh_next  = sh_in; // (R03)
				cnt_next = cnt_reg + CNT_ONE;
				if (cnt_reg == TYPE_CNT) begin // (R05)
					addr_next = sh_reg[ADDR_W-1:0]; // (R01)
					cnt_next  = CNT_ZERO;
					if (mosi_s == TYPE_WRITE) begin
						state_next = ST_WR;
					end else begin
						state_next = ST_RD;
						rd_sh_next = rd_word;
						miso_next  = rd_word[DATA_W-1]; // (R07)
						oe_next    = 1'b1;
					end
				end
			end
			ST_WR: if (sck_rise) begin
				sh_next  = sh_in; // (R06)
				cnt_next = cnt_reg + CNT_ONE;
				if (cnt_reg == LAST_CNT) begin
					// commit only a complete word (R15)
					mem_we     = 1'b1;
					wv_next    = 1'b1;
					wr_next    = mem_wr;
					state_next = ST_HOLD;
				end
			end
			ST_RD: if (sck_rise) begin
				if (cnt_reg == LAST_CNT) begin
					// lsb sampled on the previous fall; let go (R14)
					oe_next    = 1'b0;
					miso_next  = PIN_RST;
					state_next = ST_HOLD;
				end else begin
					cnt_next   = cnt_reg + CNT_ONE;
					rd_sh_next = {rd_sh_reg[DATA_W-2:0], 1'b0};
					miso_next  = rd_sh_reg[DATA_W-2]; // (R07)
				end
			end
			ST_HOLD: begin
				// extra clocks before deselect are ignored (R09)
				state_next = ST_HOLD;
			end
			default: begin
				state_next = ST_IDLE;
				oe_next    = 1'b0;
			end
			endcase
		end
	end

	// sequence registers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= CNT_ZERO;
			sh_reg    <= DATA_RST;
			rd_sh_reg <= DATA_RST;
			addr_reg  <= ADDR_RST;
			miso_reg  <= PIN_RST;
			oe_reg    <= 1'b0;
			wv_reg    <= 1'b0;
			wr_reg    <= '{addr: ADDR_RST, data: DATA_RST};
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			rd_sh_reg <= rd_sh_next;
			addr_reg  <= addr_next;
			miso_reg  <= miso_next;
			oe_reg    <= oe_next;
			wv_reg    <= wv_next;
			wr_reg    <= wr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core-side read port and outputs

	logic [DATA_W-1:0] cfg_reg;
	logic              busy_reg;

	// registered lookup keeps cfg_data_o straight from a flop
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_reg  <= DATA_RST;
			busy_reg <= 1'b0;
		end else begin
			cfg_reg  <= regs_mem[cfg_addr_i];
			busy_reg <= (state_next != ST_IDLE);
		end
	end

	assign miso_o     = miso_reg;
	assign miso_oe_o  = oe_reg; // (R14)
	assign wr_valid_o = wv_reg;
	assign wr_o       = wr_reg;
	assign cfg_data_o = cfg_reg;
	assign busy_o     = busy_reg;

endmodule // ssrp_port

// ---- tb/ssrp_port_chk.sv ----
// Purpose: port checks of the serial register port
// Assumes: sck far slower than core_clk_i
// Notes:   bound from the bench top
`timescale 1ns/10ps
module ssrp_port_chk import ssrp_pkg::*; (
	// top ports
	input wire logic              core_clk_i, rst_i, sck_i, sel_n_i,
	input wire logic              mosi_i, miso_o, miso_oe_o,
	input wire logic              wr_valid_o, busy_o,
	input wire logic [ADDR_W-1:0] cfg_addr_i,
	input wire logic [DATA_W-1:0] cfg_data_o,
	input ssrp_wr_t               wr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// released pin rests low
	property p_rel; !miso_oe_o |-> !miso_o; endproperty
	a_rel: assert property (p_rel) else $error("miso high off");
	property p_desel; sel_n_i[*6] |-> !miso_oe_o; endproperty
	a_desel: assert property (p_desel) else $error("oe unselected");
	property p_oe_busy; miso_oe_o |-> busy_o; endproperty
	a_oe_busy: assert property (p_oe_busy) else $error("oe idle");
	// sync needs three cycles, five allowed
	property p_bsy; (!sel_n_i)[*5] |-> busy_o; endproperty
	a_bsy: assert property (p_bsy) else $error("busy late");
	property p_idle; sel_n_i[*5] |-> !busy_o; endproperty
	a_idle: assert property (p_idle) else $error("busy stuck");
	property p_pulse; wr_valid_o |=> !wr_valid_o; endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_hold; !wr_valid_o |-> $stable(wr_o); endproperty
	a_hold: assert property (p_hold) else $error("wr_o moved");
	property p_land;
		wr_valid_o ##1 (cfg_addr_i == wr_o.addr)[*2] |=> cfg_data_o == wr_o.data;
	endproperty
	a_land: assert property (p_land) else $error("word not stored");
	// read starts only on a zero type bit
	property p_rd; $rose(miso_oe_o) |-> !mosi_i && !sel_n_i; endproperty
	a_rd: assert property (p_rd) else $error("bad read start");
	// bits move only after an sck rise
	property p_shift; (!sck_i && !sel_n_i)[*6] |-> $stable(miso_o); endproperty
	a_shift: assert property (p_shift) else $error("miso moved");
	c_wr: cover property (wr_valid_o);
	c_rd: cover property ($rose(miso_oe_o));
	c_gap: cover property ($fell(busy_o) ##[1:60] $rose(busy_o));
endmodule // ssrp_port_chk

// ---- tb/ssrp_master.sv ----
// Purpose: behavioural serial master
// Assumes: sck 160 ns, still low between frames
// Notes:   idle mosi shows the inverted last bit
`timescale 1ns/10ps
module ssrp_master (
	// serial pins
	output logic     sck_o,
	output logic     sel_n_o,
	output logic     mosi_o,
	input wire logic miso_i
);
	localparam int H = 80;
	initial begin
		sck_o = 1'b0;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// one access; fewer than 26 bits aborts
	task automatic access(input logic wr, input logic [8:0] a,
		input logic [15:0] d, input int nb, output logic [15:0] q);
		logic [25:0] f;
		f = {a, wr, d};
		q = 'x;
		sel_n_o = 1'b0;
		#(2*H);
		for (int i = 25; i >= 26 - nb; i--) begin
			mosi_o = f[i];
			#H sck_o = 1'b1;
			#H sck_o = 1'b0;
			if (i > 0 && i < 17) q[i-1] = miso_i;
		end
		mosi_o = ~mosi_o;
		#(2*H) sel_n_o = 1'b1;
		#(4*H);
	endtask
endmodule // ssrp_master

// ---- tb/ssrp_port_tb_top.sv ----
// Purpose: self-checking bench of the serial register port
// Assumes: core 8 ns, partner sck 160 ns
// Notes:   writes, reads back, aborts
`timescale 1ns/10ps
module ssrp_port_tb_top;
	import ssrp_pkg::*;
	logic              core_clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              sck_i, sel_n_i, mosi_i, miso_o, miso_oe_o;
	logic              wr_valid_o, busy_o;
	logic [ADDR_W-1:0] cfg_addr_i = '0;
	logic [DATA_W-1:0] cfg_data_o, q;
	ssrp_wr_t          wr_o;
	wire               miso_w = miso_oe_o ? miso_o : 1'bz;
	int                n_mismatch, num_checks, n_wr;
	initial forever #4 core_clk_i = ~core_clk_i;
	// count on the falling edge, away from the edge that launches the pulse
	always @(negedge core_clk_i) if (wr_valid_o === 1'b1) n_wr++;
	ssrp_port uut (.core_clk_i, .rst_i, .sck_i, .sel_n_i, .mosi_i, .miso_o,
		.miso_oe_o, .cfg_addr_i, .cfg_data_o, .wr_valid_o, .wr_o, .busy_o);
	ssrp_master mst (.sck_o(sck_i), .sel_n_o(sel_n_i), .mosi_o(mosi_i),
		.miso_i(miso_w));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// core lookup is registered, so wait two edges
	task automatic core_rd(input logic [8:0] a);
		@(posedge core_clk_i) #1 cfg_addr_i = a;
		repeat (2) @(posedge core_clk_i);
		#1 q = cfg_data_o;
	endtask
	task automatic t_wr_rd(input logic [8:0] a, input logic [15:0] d);
		int n0;
		n0 = n_wr;
		@(posedge core_clk_i) #1 cfg_addr_i = a;
		mst.access(1'b1, a, d, 26, q);
		chk(n_wr, n0 + 1);
		chk(wr_o, {a, d});
		@(posedge core_clk_i) #1 mst.access(1'b0, a, 16'h0000, 26, q);
		chk(q, d);
		core_rd(a);
		chk(q, d);
	endtask
	// select raised early: nothing lands, pin let go
	task automatic t_abort(input logic [8:0] a, input logic [15:0] d);
		int n0;
		n0 = n_wr;
		@(posedge core_clk_i) #1 mst.access(1'b1, a, ~d, 25, q);
		chk(n_wr, n0);
		core_rd(a);
		chk(q, d);
		@(posedge core_clk_i) #1 mst.access(1'b0, a, 16'h0000, 18, q);
		chk(miso_oe_o, 1'b0);
		chk(q[15:7], d[15:7]);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1 chk(miso_oe_o, 1'b0);
		t_wr_rd(9'h000, 16'hA5C3);
		t_wr_rd(9'h1FF, 16'h5A3C);
		t_wr_rd(9'h0A5, 16'hFFFF);
		t_abort(9'h0A5, 16'hFFFF);
		t_wr_rd(9'h1FF, 16'h0001);
		results();
	end
	// ten accesses take about 47 us; allow a little over four times that
	initial begin
		#200_000;
		n_mismatch++;
		results();
	end
endmodule // ssrp_port_tb_top
bind ssrp_port ssrp_port_chk chk_i (.core_clk_i, .rst_i, .sck_i, .sel_n_i,
	.mosi_i, .miso_o, .miso_oe_o, .cfg_addr_i, .cfg_data_o, .wr_valid_o,
	.wr_o, .busy_o);
